/* File: logic/isr_defines.svh */
// Register offsets, field positions, reset values and timing for the status slice.
// What this block does
// - Lower inductance limit is upper byte here, low byte from address 0x18.
// - Lower-limit upper byte writable during active conversion, applied without stopping.
// - Written low byte is buffered, applied only when upper byte is written.
// - Status bit 7 reads 1 when sensor oscillation is missing.
// - Status bit 6 is active low result-ready for combined loss and inductance.
// - Over-limit flags latch low; cleared only by writing 0x00 to 0x0A.
// - Loss over-limit flag reported only when function select is b00'0001.
// - Status bit 5 reads 0 once loss result exceeded loss upper limit.
// - Status bit 4 is the loss hysteresis comparator.
// - Inductance over-limit flag reported only when function select is b00'1000.
// - Status bit 3 reads 0 once inductance exceeded inductance upper limit.
// - Status bit 2 is the inductance hysteresis comparator.
// - Status bit 0 reads 1 during power-on reset; writes ignored then.
// - Loss result high byte at 0x22, low byte at 0x21.
// - Inductance result low byte at 0x23, high byte at 0x24.
// - Status and results are read-only and reset to zero.
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH
`define ISR_ADDR_LLIM_LSB 7'h18
`define ISR_ADDR_LLIM_MSB 7'h19
`define ISR_ADDR_FUNC_SEL 7'h0A
`define ISR_ADDR_STATUS 7'h20
`define ISR_ADDR_LOSS_LSB 7'h21
`define ISR_ADDR_LOSS_MSB 7'h22
`define ISR_ADDR_IND_LSB 7'h23
`define ISR_ADDR_IND_MSB 7'h24
`define ISR_BIT_OSC_ERR 7
`define ISR_BIT_RDY_N 6
`define ISR_BIT_LOSS_OVER 5
`define ISR_BIT_LOSS_WIN 4
`define ISR_BIT_IND_OVER 3
`define ISR_BIT_IND_WIN 2
`define ISR_BIT_POR 0
`define ISR_SEL_LOSS 6'h01
`define ISR_SEL_IND 6'h08
`define ISR_CLEAR_VAL 8'h00
`define ISR_RESET_BYTE 8'h00
`define ISR_POR_CYCLES 16
`endif

/* File: logic/isr_pkg.sv */
// Types shared by the status and result register slice.
package isr_pkg;
   typedef enum logic [1:0] {
      ISR_CMD,
      ISR_ADDR,
      ISR_DATA
   } isr_spi_state_t;
endpackage

/* File: logic/isr_regs.sv */
// Status, lower-limit and result registers reached over the serial port.
`timescale 1ns/1ps
`include "isr_defines.svh"
module isr_regs #(
   parameter int POR_CYCLES = `ISR_POR_CYCLES
) (
   input wire logic i_clk, // Core clock, 40 MHz.
   input wire logic i_reset_n, // Asynchronous reset, active low.
   input wire logic i_sck, // Serial clock pin.
   input wire logic i_csb_n, // Serial chip select, active low.
   input wire logic i_mosi, // Serial data in.
   output logic o_miso, // Serial data out.
   output logic o_miso_oe, // High while driving serial data out.
   input wire logic i_osc_missing, // Core sees no sensor oscillation.
   input wire logic i_result_valid, // One-cycle pulse, new result pair.
   input wire logic [15:0] i_loss_result, // Loss conversion result.
   input wire logic [15:0] i_ind_result, // Inductance conversion result.
   input wire logic [15:0] i_loss_upper_limit, // Loss upper limit.
   input wire logic [15:0] i_loss_lower_limit, // Loss lower limit.
   input wire logic [15:0] i_ind_upper_limit, // Inductance upper limit.
   input wire logic [5:0] i_func_select, // Interrupt function select.
   output logic [15:0] o_ind_lower_limit, // Applied inductance lower limit.
   output logic o_por_busy // High while power-on reset runs.
);
   logic [2:0] sck_sync_reg;
   logic [1:0] csb_sync_reg;
   logic [1:0] mosi_sync_reg;
   logic [1:0] osc_sync_reg;
   isr_pkg::isr_spi_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic rd_reg;
   logic [6:0] addr_reg;
   logic [7:0] llim_lsb_buf_reg;
   logic [7:0] llim_msb_reg;
   logic [15:0] llim_reg;
   logic [15:0] loss_reg;
   logic [15:0] ind_reg;
   logic [7:0] loss_hold_reg;
   logic [15:0] ind_hold_reg;
   logic ready_n_reg;
   logic loss_over_n_reg;
   logic loss_win_reg;
   logic ind_over_n_reg;
   logic ind_win_reg;
   logic [7:0] status_reg;
   logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_reg;
   logic por_reg;
   logic sck_rise;
   logic sck_fall;
   logic sel;
   logic byte_done;
   logic [7:0] rx_byte;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] rd_data;
   logic [7:0] status_next;
   logic loss_over;
   logic ind_over;

   // The serial pins are not on this clock; logic reads stage two, and the serial clock edge detect also reads stage three.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_sync_reg <= 3'h0;
         csb_sync_reg <= 2'h3;
         mosi_sync_reg <= 2'h0;
         osc_sync_reg <= 2'h0;
      end else begin
         sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
         csb_sync_reg <= {csb_sync_reg[0], i_csb_n};
         mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
         osc_sync_reg <= {osc_sync_reg[0], i_osc_missing};
      end
   end

   assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
   assign sel = ~csb_sync_reg[1];
   assign byte_done = sel && sck_rise && (bit_cnt_reg == 3'h7);
   assign rx_byte = {shift_reg[6:0], mosi_sync_reg[1]};
   assign wr_stb = byte_done && (state_reg == isr_pkg::ISR_DATA) && !rd_reg;
   assign rd_stb = byte_done && (state_reg == isr_pkg::ISR_CMD) && rx_byte[7];

   // Frame is one command byte (bit 7 read, bits 6:0 address) and data.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= isr_pkg::ISR_CMD;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         rd_reg <= 1'b0;
         addr_reg <= 7'h00;
      end else if (!sel) begin
         state_reg <= isr_pkg::ISR_CMD;
         bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
         shift_reg <= rx_byte;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7) begin
            case (state_reg)
               isr_pkg::ISR_CMD: begin
                  rd_reg <= rx_byte[7];
                  addr_reg <= rx_byte[6:0];
                  state_reg <= isr_pkg::ISR_DATA;
               end
               isr_pkg::ISR_DATA: state_reg <= isr_pkg::ISR_CMD;
               default: state_reg <= isr_pkg::ISR_CMD;
            endcase
         end
      end
   end

   always_comb begin
      case (rx_byte[6:0])
         `ISR_ADDR_LLIM_MSB: rd_data = llim_msb_reg;
         `ISR_ADDR_STATUS: rd_data = status_reg;
         `ISR_ADDR_LOSS_LSB: rd_data = loss_reg[7:0];
         `ISR_ADDR_LOSS_MSB: rd_data = loss_hold_reg;
         `ISR_ADDR_IND_LSB: rd_data = ind_hold_reg[7:0];
         `ISR_ADDR_IND_MSB: rd_data = ind_hold_reg[15:8];
         default: rd_data = 8'h00;
      endcase
   end

   // Read data shifts out MSB first on falling edges, starting with the one that ends the command byte.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_reg <= 8'h00;
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
      end else if (!sel) begin
         o_miso_oe <= 1'b0;
         o_miso <= 1'b0;
      end else if (rd_stb) begin
         tx_reg <= rd_data;
      end else if (sck_fall && state_reg == isr_pkg::ISR_DATA && rd_reg) begin
         o_miso_oe <= 1'b1;
         o_miso <= tx_reg[7];
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   // Reading the loss low byte freezes the rest of the pair.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         loss_hold_reg <= `ISR_RESET_BYTE;
         ind_hold_reg <= 16'h0000;
      end else if (rd_stb && rx_byte[6:0] == `ISR_ADDR_LOSS_LSB) begin
         loss_hold_reg <= loss_reg[15:8];
         ind_hold_reg <= ind_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         por_cnt_reg <= '0;
         por_reg <= 1'b1;
      end else if (por_cnt_reg == ($clog2(POR_CYCLES+1))'(POR_CYCLES)) begin
         por_reg <= 1'b0;
      end else begin
         por_cnt_reg <= por_cnt_reg + 1'b1;
      end
   end

   // Upper-byte limit writes act at once, so conversions keep running meanwhile.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         llim_lsb_buf_reg <= 8'h00;
         llim_msb_reg <= 8'h00;
         llim_reg <= 16'h0000;
      end else if (wr_stb && !por_reg) begin
         if (addr_reg == `ISR_ADDR_LLIM_LSB)
            llim_lsb_buf_reg <= rx_byte;
         if (addr_reg == `ISR_ADDR_LLIM_MSB) begin
            llim_msb_reg <= rx_byte;
            llim_reg <= {rx_byte, llim_lsb_buf_reg};
         end
      end
   end

   assign loss_over = i_loss_result > i_loss_upper_limit;
   assign ind_over = i_ind_result > i_ind_upper_limit;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         loss_reg <= 16'h0000;
         ind_reg <= 16'h0000;
         ready_n_reg <= 1'b0;
      end else if (i_result_valid) begin
         loss_reg <= i_loss_result;
         ind_reg <= i_ind_result;
         ready_n_reg <= 1'b0;
      end else if (rd_stb && rx_byte[6:0] == `ISR_ADDR_LOSS_LSB) begin
         ready_n_reg <= 1'b1;
      end
   end

   // A new over-limit event beats a clear in the same cycle.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         loss_over_n_reg <= 1'b0;
         ind_over_n_reg <= 1'b0;
         loss_win_reg <= 1'b0;
         ind_win_reg <= 1'b0;
      end else begin
         if (i_result_valid && loss_over)
            loss_over_n_reg <= 1'b0;
         else if (wr_stb && addr_reg == `ISR_ADDR_FUNC_SEL
                  && rx_byte == `ISR_CLEAR_VAL && !por_reg)
            loss_over_n_reg <= 1'b1;
         if (i_result_valid && ind_over)
            ind_over_n_reg <= 1'b0;
         else if (wr_stb && addr_reg == `ISR_ADDR_FUNC_SEL
                  && rx_byte == `ISR_CLEAR_VAL && !por_reg)
            ind_over_n_reg <= 1'b1;
         if (i_result_valid && loss_over)
            loss_win_reg <= 1'b0;
         else if (i_result_valid && i_loss_result < i_loss_lower_limit)
            loss_win_reg <= 1'b1;
         if (i_result_valid && ind_over)
            ind_win_reg <= 1'b0;
         else if (i_result_valid && i_ind_result < llim_reg)
            ind_win_reg <= 1'b1;
      end
   end

   always_comb begin
      status_next = 8'h00;
      status_next[`ISR_BIT_OSC_ERR] = osc_sync_reg[1];
      status_next[`ISR_BIT_RDY_N] = ready_n_reg;
      status_next[`ISR_BIT_LOSS_OVER] =
         (i_func_select == `ISR_SEL_LOSS) & loss_over_n_reg;
      status_next[`ISR_BIT_LOSS_WIN] = loss_win_reg;
      status_next[`ISR_BIT_IND_OVER] =
         (i_func_select == `ISR_SEL_IND) & ind_over_n_reg;
      status_next[`ISR_BIT_IND_WIN] = ind_win_reg;
      status_next[`ISR_BIT_POR] = por_reg;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         status_reg <= `ISR_RESET_BYTE;
         o_ind_lower_limit <= 16'h0000;
         o_por_busy <= 1'b0;
      end else begin
         status_reg <= status_next;
         o_ind_lower_limit <= llim_reg;
         o_por_busy <= por_reg;
      end
   end

   AST_LIMIT_APPLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_stb && !por_reg && addr_reg == `ISR_ADDR_LLIM_MSB)
      |=> llim_reg == {$past(rx_byte), $past(llim_lsb_buf_reg)})
      else $error("lower limit not applied from both bytes");
   AST_LSB_BUFFERED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_stb && addr_reg == `ISR_ADDR_LLIM_LSB) |=> $stable(llim_reg))
      else $error("low byte changed the limit before upper byte");
   AST_POR_BLOCKS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      por_reg |=> $stable(llim_msb_reg))
      else $error("write accepted during power-on reset");
   AST_LOSS_LATCH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_result_valid && loss_over) |=> !loss_over_n_reg)
      else $error("loss over-limit not latched low");
   sequence s_clear_write;
      wr_stb && !por_reg && addr_reg == `ISR_ADDR_FUNC_SEL
      && rx_byte == `ISR_CLEAR_VAL && !i_result_valid;
   endsequence
   AST_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_clear_write |=> loss_over_n_reg && ind_over_n_reg)
      else $error("over-limit flags not cleared");
   AST_LOSS_GATE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_func_select != `ISR_SEL_LOSS) |=> !status_reg[`ISR_BIT_LOSS_OVER])
      else $error("loss flag shown without select");
   AST_IND_GATE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_func_select != `ISR_SEL_IND) |=> !status_reg[`ISR_BIT_IND_OVER])
      else $error("inductance flag shown without select");
   AST_IND_WIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_result_valid && ind_over) |=> !ind_win_reg ##1 !status_reg[2])
      else $error("inductance window not low after over");
   AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (rd_stb && rx_byte[6:0] == `ISR_ADDR_LOSS_LSB)
      |=> ind_hold_reg == $past(ind_reg))
      else $error("result pair not captured");
   AST_RES0: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !status_reg[1])
      else $error("reserved status bit set");
endmodule

/* File: dv/isr_host_model.sv */
// Serial host model that sends command and data byte frames.
`timescale 1ns/1ps
module isr_host_model (
   input wire logic i_clk, // Core clock used for timing.
   input wire logic i_miso, // Serial data from the device.
   input wire logic i_miso_oe, // High while the device drives data.
   output logic o_sck, // Serial clock, low outside frames.
   output logic o_csb_n, // Chip select, active low.
   output logic o_mosi // Serial data to the device.
);
   initial begin
      o_sck = 1'b0;
      o_csb_n = 1'b1;
      o_mosi = 1'b0;
   end
   // Four core clocks per phase give a 200 ns serial clock period.
   task automatic xfer(input logic rw, input logic [6:0] addr,
      input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] frame;
      frame = {rw, addr, wd};
      @(posedge i_clk);
      o_csb_n <= 1'b0;
      for (int b = 15; b >= 0; b--) begin
         o_mosi <= frame[b];
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_clk);
         // Sampling just before the fall tolerates the input sync delay.
         if (b < 8) begin
            rd[b] = i_miso_oe ? i_miso : 1'bx;
         end
         o_sck <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      o_csb_n <= 1'b1;
      // A released line shows the inverse, so a stale bit never matches.
      o_mosi <= ~frame[0];
      repeat (4) @(posedge i_clk);
   endtask
endmodule

/* File: dv/inductive_status_result_regs_bench.sv */
// Self-checking bench for the status and result register slice.
`timescale 1ns/1ps
`include "isr_defines.svh"
module inductive_status_result_regs_bench;
   localparam logic [15:0] LUP = 16'h8000;
   localparam logic [15:0] LLO = 16'h4000;
   localparam logic [15:0] IUP = 16'h9000;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_osc = 1'b0;
   logic i_valid = 1'b0;
   logic [15:0] i_loss = 16'h0000;
   logic [15:0] i_ind = 16'h0000;
   logic [5:0] i_sel = 6'h00;
   logic sck, csb_n, mosi, miso, miso_oe, por_busy;
   logic [15:0] ind_lo, cap_loss, cap_ind, ilim;
   logic e_osc, e_rdy, e_lof, e_lw, e_iof, e_iw;
   logic [7:0] rd;
   int num_errors = 0;
   int checked = 0;
   int seed = 23;
   always #12.5 i_clk = ~i_clk;
   isr_regs #(.POR_CYCLES(300)) isr_regs_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sck(sck), .i_csb_n(csb_n),
      .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
      .i_osc_missing(i_osc), .i_result_valid(i_valid),
      .i_loss_result(i_loss), .i_ind_result(i_ind),
      .i_loss_upper_limit(LUP), .i_loss_lower_limit(LLO),
      .i_ind_upper_limit(IUP), .i_func_select(i_sel),
      .o_ind_lower_limit(ind_lo), .o_por_busy(por_busy)
   );
   isr_host_model isr_host_model_inst (
      .i_clk(i_clk), .i_miso(miso), .i_miso_oe(miso_oe),
      .o_sck(sck), .o_csb_n(csb_n), .o_mosi(mosi)
   );
   function automatic logic win(logic cur, logic [15:0] v, up, lo);
      return (v > up) ? 1'b0 : (v < lo) ? 1'b1 : cur;
   endfunction
   // Status byte as the host should read it under the present select.
   function automatic logic [7:0] stat(logic [5:0] sel);
      return {e_osc, e_rdy, e_lof & (sel == `ISR_SEL_LOSS), e_lw,
         e_iof & (sel == `ISR_SEL_IND), e_iw, 2'b00};
   endfunction
   function automatic logic [15:0] pick();
      int k;
      k = $random(seed) & 3;
      return (k == 0) ? 16'h0005 : (k == 1) ? 16'h6000 :
         (k == 2) ? 16'hF000 : 16'($random(seed));
   endfunction
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic xfer(logic rw, logic [6:0] a, logic [7:0] wd);
      isr_host_model_inst.xfer(rw, a, wd, rd);
   endtask
   task automatic result(logic [15:0] l, logic [15:0] n);
      @(posedge i_clk);
      i_loss <= l;
      i_ind <= n;
      i_valid <= 1'b1;
      @(posedge i_clk);
      i_valid <= 1'b0;
      e_rdy = 1'b0;
      e_lw = win(e_lw, l, LUP, LLO);
      e_iw = win(e_iw, n, IUP, ilim);
      // Flags latch on any over-limit result; the select only gates display.
      if (l > LUP) e_lof = 1'b0;
      if (n > IUP) e_iof = 1'b0;
   endtask
   task automatic complete_run();
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end
   initial begin
      logic [7:0] lsb, msb, wd, st;
      logic o;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      check("por_busy", 16'(por_busy), 16'h0001);
      // This write lands inside the power-on phase and must be dropped.
      xfer(1'b0, `ISR_ADDR_LLIM_MSB, 8'h55);
      xfer(1'b1, `ISR_ADDR_STATUS, 8'h00);
      check("por_bit", 16'(rd[0]), 16'h0001);
      for (int t = 0; t < 8 && rd[0] !== 1'b0; t++) begin
         xfer(1'b1, `ISR_ADDR_STATUS, 8'h00);
      end
      check("st_rst", 16'(rd), 16'h0000);
      check("por_done", 16'(por_busy), 16'h0000);
      for (int a = 0; a < 4; a++) begin
         xfer(1'b0, `ISR_ADDR_LOSS_LSB + 7'(a), 8'hFF);
         xfer(1'b1, `ISR_ADDR_LOSS_LSB + 7'(a), 8'h00);
         check("res_rst", 16'(rd), 16'h0000);
      end
      xfer(1'b1, 7'h7F, 8'h00);
      check("unmapped", 16'(rd), 16'h0000);
      lsb = 8'($random(seed));
      msb = 8'h10 + 8'($random(seed) & 31);
      xfer(1'b0, `ISR_ADDR_LLIM_LSB, lsb);
      check("llim_buf", ind_lo, 16'h0000);
      xfer(1'b0, `ISR_ADDR_LLIM_MSB, msb);
      ilim = {msb, lsb};
      check("llim", ind_lo, ilim);
      xfer(1'b1, `ISR_ADDR_LLIM_MSB, 8'h00);
      check("llim_rd", 16'(rd), 16'(msb));
      {e_rdy, e_lof, e_lw, e_iof, e_iw} = 5'h10;
      for (int i = 0; i < 20; i++) begin
         o = 1'($random(seed));
         i_osc <= o;
         e_osc = o;
         i_sel <= (i % 3 == 0) ? `ISR_SEL_LOSS :
            (i % 3 == 1) ? `ISR_SEL_IND : 6'h00;
         result(pick(), pick());
         cap_loss = i_loss;
         cap_ind = i_ind;
         if (i % 2 == 1) begin
            wd = (i % 4 == 1) ? 8'h5A : `ISR_CLEAR_VAL;
            xfer(1'b0, `ISR_ADDR_FUNC_SEL, wd);
            if (wd == `ISR_CLEAR_VAL) begin
               e_lof = 1'b1;
               e_iof = 1'b1;
            end
         end
         st = stat(i_sel);
         xfer(1'b1, `ISR_ADDR_STATUS, 8'h00);
         check("st", 16'(rd), 16'(st));
         xfer(1'b1, `ISR_ADDR_LOSS_LSB, 8'h00);
         e_rdy = 1'b1;
         check("loss_lo", 16'(rd), 16'(cap_loss[7:0]));
         if (i % 2 == 0) result(pick(), pick());
         for (int a = 1; a < 4; a++) begin
            xfer(1'b1, `ISR_ADDR_LOSS_LSB + 7'(a), 8'h00);
            st = 8'({cap_ind, cap_loss} >> (8 * a));
            check("held", 16'(rd), 16'(st));
         end
         st = stat(i_sel);
         xfer(1'b1, `ISR_ADDR_STATUS, 8'h00);
         check("st2", 16'(rd), 16'(st));
         check("st2_win", 16'(rd[2]), 16'(e_iw));
      end
      complete_run();
   end
endmodule
